// ==== pkg/ssa_pkg.sv ====
// Purpose: Shared constants and types for the serial adapter bus attachment
// Assumes: 10 MHz processor clock, enable clock one tenth of it
// Notes:   Register indices follow select bit and read/write line
package ssa_pkg;
   localparam int unsigned CLK_HZ        = 10000000;
   localparam int unsigned ECLK_DIV      = 10;
   localparam int unsigned ECLK_HZ       = CLK_HZ / ECLK_DIV;
   localparam int unsigned ECLK_HIGH     = ECLK_DIV / 2;
   localparam logic [3:0]  ECLK_LAST     = 4'(ECLK_DIV - 1);
   localparam logic [3:0]  ECLK_HIGH_AT  = 4'(ECLK_DIV - ECLK_HIGH);
   localparam logic [7:0]  IO_PAGE       = 8'h01;
   localparam int unsigned ADDR_W        = 23;
   localparam int unsigned PAGE_MSB      = 22;
   localparam int unsigned PAGE_LSB      = 15;
   localparam int unsigned ADDR_SIX_POS  = 5;
   localparam int unsigned ADDR_ONE_POS  = 0;
   localparam int unsigned FIFO_DEPTH    = 16;
   localparam int unsigned BYTE_W        = 8;
   // Control register fields
   localparam int unsigned CTL_RESET_LO  = 0;
   localparam int unsigned CTL_RESET_HI  = 1;
   localparam int unsigned CTL_PARITY_EN = 2;
   localparam int unsigned CTL_PARITY_OD = 3;
   localparam int unsigned CTL_RX_IE     = 7;
   localparam logic [7:0]  CTL_RESET_VAL = 8'h03;
   // Status register fields
   localparam int unsigned ST_RDRF       = 0;
   localparam int unsigned ST_TDRE       = 1;
   localparam int unsigned ST_FE         = 4;
   localparam int unsigned ST_OVRN       = 5;
   localparam int unsigned ST_PE         = 6;
   localparam int unsigned ST_IRQ        = 7;
   localparam int unsigned BAUD_DIV      = 16;
   localparam int unsigned FRAME_BITS    = 11;

   typedef enum logic [2:0] {
      SSA_IDLE  = 3'b001,
      SSA_WAIT  = 3'b010,
      SSA_XFER  = 3'b100
   } ssa_cyc_e;
endpackage : ssa_pkg

// ==== pkg/ssa_stream_if.sv ====
// Purpose: Valid/ready byte stream between adapter core and FIFO
// Assumes: Single clock domain
// Notes:   One word moves when valid and ready are both high
interface ssa_stream_if #(parameter int unsigned W = 8);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : ssa_stream_if

// ==== logic/ssa_fifo.sv ====
// Purpose: Parameterised synchronous FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Full and empty come from pointer comparison with wrap bit
module ssa_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic clk_en,
   ssa_stream_if.snk in_s,
   ssa_stream_if.src out_s
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign empty       = (wr_ptr_reg == rd_ptr_reg);
   assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_s.ready  = !full;
   assign out_s.valid = !empty;
   assign out_s.data  = mem[rd_ptr_reg[AW-1:0]];
   assign push        = in_s.valid && !full;
   assign pop         = out_s.ready && !empty;

   always_ff @(posedge ref_clk) begin
      if (clk_en && push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_s.data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule : ssa_fifo

// ==== logic/ssa_attach.sv ====
// Purpose: Two byte-lane serial adapters on a 16-bit bus with synchronous enable-clock cycle
// Assumes: Bus inputs synchronous to ref_clk; the master aligns its cycle to eclk
// Notes:   Receive path of each adapter passes through a 16-word FIFO

module ssa_attach (
   input  wire logic                         ref_clk,
   input  wire logic                         resetn,
   input  wire logic                         clk_en,
   input  wire logic [ssa_pkg::ADDR_W-1:0]   addr,
   input  wire logic                         as_n,
   input  wire logic                         rw,
   input  wire logic                         low_byte_strobe_n,
   input  wire logic                         high_byte_strobe_n,
   input  wire logic                         valid_memory_addr_n,
   input  wire logic [15:0]                  data_in,
   output logic      [15:0]                  data_out,
   output logic      [15:0]                  data_oe_n,
   output logic                              valid_peripheral_addr_n,
   output logic                              eclk,
   input  wire logic [1:0]                   rx_serial,
   output logic      [1:0]                   tx_serial,
   output logic      [1:0]                   irq_n
);
   import ssa_pkg::*;

   logic [3:0]  ediv_reg;
   logic        eclk_reg;
   logic        vpa_reg;
   logic        sel_page;
   logic        cyc_end;
   ssa_cyc_e    cyc_reg;
   logic [15:0] dout_reg;
   logic [1:0]  oe_reg;
   logic        rearm_reg;

   // Enable clock: low 5 cycles then high 5
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ediv_reg <= '0;
      end else if (clk_en) begin
         ediv_reg <= (ediv_reg == ECLK_LAST) ? 4'h0 : ediv_reg + 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         eclk_reg <= 1'b0;
      end else if (clk_en) begin
         eclk_reg <= ((ediv_reg + 4'h1) >= ECLK_HIGH_AT) && (ediv_reg != ECLK_LAST);
      end
   end
   assign eclk = eclk_reg;

   // Page and bit-six decode
   assign sel_page = !as_n && (addr[PAGE_MSB:PAGE_LSB] == IO_PAGE) && addr[ADDR_SIX_POS]
                     && !(low_byte_strobe_n && high_byte_strobe_n);
   assign cyc_end  = eclk_reg && (ediv_reg == ECLK_LAST);

   // Decode again only after strobe seen high
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rearm_reg <= 1'b1;
      end else if (clk_en) begin
         if (as_n) begin
            rearm_reg <= 1'b1;
         end else if ((cyc_reg == SSA_IDLE) && sel_page) begin
            rearm_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cyc_reg <= SSA_IDLE;
         vpa_reg <= 1'b0;
      end else if (clk_en) begin
         case (cyc_reg)
            SSA_IDLE: begin
               if (sel_page && rearm_reg) begin
                  cyc_reg <= SSA_WAIT;
                  vpa_reg <= 1'b1;
               end
            end
            SSA_WAIT: begin
               if (as_n) begin
                  cyc_reg <= SSA_IDLE;
                  vpa_reg <= 1'b0;
               end else if (!valid_memory_addr_n && eclk_reg) begin
                  cyc_reg <= SSA_XFER;
               end
            end
            SSA_XFER: begin
               if (cyc_end || as_n) begin
                  cyc_reg <= SSA_IDLE;
                  vpa_reg <= 1'b0;
               end
            end
            default: begin
               cyc_reg <= SSA_IDLE;
               vpa_reg <= 1'b0;
            end
         endcase
      end
   end
   assign valid_peripheral_addr_n = !vpa_reg;

   // Register access strobe: one per cycle, enable high, chip selected
   logic       acc_go;
   logic [1:0] lane_sel;
   assign acc_go   = clk_en && (cyc_reg == SSA_XFER) && cyc_end && !valid_memory_addr_n;
   assign lane_sel = {!high_byte_strobe_n, !low_byte_strobe_n};

   // Per-adapter state, lane 0 low byte, lane 1 high byte
   logic [7:0] rd_byte [2];
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_adp
         logic [7:0] ctl_reg;
         logic [7:0] txd_reg;
         logic       tx_full_reg;
         logic [10:0] tsh_reg;
         logic [3:0]  tbit_reg;
         logic [3:0]  tdiv_reg;
         logic        tbusy_reg;
         logic [10:0] rsh_reg;
         logic [3:0]  rbit_reg;
         logic [3:0]  rdiv_reg;
         logic        rbusy_reg;
         logic        fe_reg;
         logic        pe_reg;
         logic        ovr_reg;
         logic [7:0]  status;
         logic        wr_hit;
         logic        rd_hit;
         logic        rx_par;
         logic        in_reset;
         ssa_stream_if #(.W(BYTE_W)) rx_in ();
         ssa_stream_if #(.W(BYTE_W)) rx_out ();

         assign wr_hit   = acc_go && lane_sel[g] && !rw;
         assign rd_hit   = acc_go && lane_sel[g] && rw;
         assign in_reset = ctl_reg[CTL_RESET_HI] && ctl_reg[CTL_RESET_LO];
         assign rx_par   = ^rsh_reg[9:2] ^ ctl_reg[CTL_PARITY_OD];

         ssa_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
            .ref_clk (ref_clk),
            .resetn  (resetn && !in_reset),
            .clk_en  (clk_en),
            .in_s    (rx_in),
            .out_s   (rx_out)
         );
         assign rx_out.ready = rd_hit && addr[ADDR_ONE_POS];

         always_comb begin
            status          = '0;
            status[ST_RDRF] = rx_out.valid;
            status[ST_TDRE] = !tx_full_reg;
            status[ST_FE]   = fe_reg;
            status[ST_OVRN] = ovr_reg;
            status[ST_PE]   = pe_reg;
         end
         assign rd_byte[g] = addr[ADDR_ONE_POS] ? rx_out.data : status;

         // Write side: bit one low control, high transmit data
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               ctl_reg     <= CTL_RESET_VAL;
               txd_reg     <= '0;
               tx_full_reg <= 1'b0;
            end else if (clk_en) begin
               if (wr_hit && !addr[ADDR_ONE_POS]) begin
                  ctl_reg <= data_in[g*8 +: 8];
               end
               if (wr_hit && addr[ADDR_ONE_POS] && !in_reset) begin
                  txd_reg     <= data_in[g*8 +: 8];
                  tx_full_reg <= 1'b1;
               end else if (!tbusy_reg || in_reset) begin
                  tx_full_reg <= 1'b0;
               end
            end
         end

         // Transmitter: start, 8 data, parity, stop
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               tsh_reg   <= '1;
               tbit_reg  <= '0;
               tdiv_reg  <= '0;
               tbusy_reg <= 1'b0;
            end else if (clk_en) begin
               if (in_reset) begin
                  tbusy_reg <= 1'b0;
                  tsh_reg   <= '1;
               end else if (!tbusy_reg && tx_full_reg) begin
                  tsh_reg   <= {1'b1, (^txd_reg ^ ctl_reg[CTL_PARITY_OD]) | !ctl_reg[CTL_PARITY_EN],
                                txd_reg, 1'b0};
                  tbusy_reg <= 1'b1;
                  tbit_reg  <= '0;
                  tdiv_reg  <= '0;
               end else if (tbusy_reg) begin
                  tdiv_reg <= tdiv_reg + 4'h1;
                  if (tdiv_reg == 4'(BAUD_DIV - 1)) begin
                     tsh_reg  <= {1'b1, tsh_reg[10:1]};
                     tbit_reg <= tbit_reg + 4'h1;
                     if (tbit_reg == 4'(FRAME_BITS - 1)) begin
                        tbusy_reg <= 1'b0;
                     end
                  end
               end
            end
         end
         assign tx_serial[g] = tsh_reg[0];

         // Receiver: sample mid-bit, strip framing bits
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               rsh_reg   <= '0;
               rbit_reg  <= '0;
               rdiv_reg  <= '0;
               rbusy_reg <= 1'b0;
            end else if (clk_en) begin
               if (in_reset) begin
                  rbusy_reg <= 1'b0;
               end else if (!rbusy_reg && !rx_serial[g]) begin
                  rbusy_reg <= 1'b1;
                  rbit_reg  <= '0;
                  rdiv_reg  <= 4'(BAUD_DIV / 2);
               end else if (rbusy_reg) begin
                  rdiv_reg <= rdiv_reg + 4'h1;
                  if (rdiv_reg == 4'(BAUD_DIV - 1)) begin
                     rsh_reg  <= {rx_serial[g], rsh_reg[10:1]};
                     rbit_reg <= rbit_reg + 4'h1;
                     if (rbit_reg == 4'(FRAME_BITS - 1)) begin
                        rbusy_reg <= 1'b0;
                     end
                  end
               end
            end
         end
         assign rx_in.valid = clk_en && rbusy_reg && !in_reset && (rdiv_reg == 4'(BAUD_DIV - 1))
                              && (rbit_reg == 4'(FRAME_BITS - 1));
         assign rx_in.data  = rsh_reg[9:2];

         // Error flags: set wins over clear on data read
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               fe_reg  <= 1'b0;
               pe_reg  <= 1'b0;
               ovr_reg <= 1'b0;
            end else if (clk_en) begin
               if (rx_in.valid) begin
                  fe_reg  <= !rx_serial[g];
                  pe_reg  <= ctl_reg[CTL_PARITY_EN] && (rx_par != rsh_reg[10]);
                  ovr_reg <= ovr_reg | !rx_in.ready;
               end else if (rd_hit && addr[ADDR_ONE_POS]) begin
                  fe_reg  <= 1'b0;
                  pe_reg  <= 1'b0;
                  ovr_reg <= 1'b0;
               end
            end
         end
         assign irq_n[g] = !(ctl_reg[CTL_RX_IE] && rx_out.valid);
      end
   endgenerate

   // Read data registered, driven on selected lanes only
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         dout_reg <= '0;
      end else if (clk_en && acc_go && rw) begin
         dout_reg <= {rd_byte[1], rd_byte[0]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         oe_reg <= '0;
      end else if (clk_en) begin
         if (acc_go && rw) begin
            oe_reg <= lane_sel;
         end else if (as_n) begin
            oe_reg <= '0;
         end
      end
   end
   assign data_out  = dout_reg;
   assign data_oe_n = ~{{8{oe_reg[1]}}, {8{oe_reg[0]}}};
endmodule : ssa_attach

// ==== tb/ssa_attach_properties.sv ====
// Purpose: Port-level assertions for ssa_attach
// Assumes: One clock; resetn synchronous, active low
// Notes:   Bound into every ssa_attach instance
module ssa_attach_properties (
   input wire logic                       ref_clk,
   input wire logic                       resetn,
   input wire logic                       clk_en,
   input wire logic [ssa_pkg::ADDR_W-1:0] addr,
   input wire logic                       as_n,
   input wire logic                       rw,
   input wire logic                       low_byte_strobe_n,
   input wire logic                       high_byte_strobe_n,
   input wire logic                       valid_memory_addr_n,
   input wire logic [15:0]                data_oe_n,
   input wire logic                       valid_peripheral_addr_n,
   input wire logic                       eclk
);
   timeunit 1ns;
   timeprecision 1ps;
   import ssa_pkg::*;
   wire logic dec;
   assign dec = !as_n && addr[PAGE_MSB:PAGE_LSB] == IO_PAGE && addr[ADDR_SIX_POS]
                && !(low_byte_strobe_n && high_byte_strobe_n);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn || !clk_en);
   chk_eclk_high_len: assert property ($rose(eclk) |-> eclk [*5] ##1 !eclk)
      else $error("enable clock high phase wrong length");
   chk_eclk_low_len: assert property ($fell(eclk) |-> !eclk [*5] ##1 eclk)
      else $error("enable clock low phase wrong length");
   chk_vpa_on_decode: assert property ($fell(as_n) && dec |=> !valid_peripheral_addr_n)
      else $error("peripheral address missing after decode");
   chk_vpa_other_dev: assert property (!as_n && !dec |=> valid_peripheral_addr_n)
      else $error("peripheral address for foreign address");
   chk_vpa_bounded: assert property ($fell(valid_peripheral_addr_n) |-> ##[1:20] valid_peripheral_addr_n)
      else $error("peripheral address held too long");
   chk_vpa_between: assert property (as_n && $past(as_n) |-> valid_peripheral_addr_n)
      else $error("peripheral address between cycles");
   chk_read_lane_low: assert property ($fell(data_oe_n[0]) |->
      $past(eclk) && !$past(valid_memory_addr_n) && !low_byte_strobe_n && rw)
      else $error("low lane driven without enabled read");
   chk_read_lane_high: assert property ($fell(data_oe_n[8]) |->
      $past(eclk) && !$past(valid_memory_addr_n) && !high_byte_strobe_n && rw)
      else $error("high lane driven without enabled read");
   chk_oe_release: assert property ($rose(as_n) |-> ##1 data_oe_n == 16'hFFFF)
      else $error("data bus not released after cycle");
   chk_write_no_drive: assert property (!as_n && !rw |=> data_oe_n == 16'hFFFF)
      else $error("data bus driven during write");
endmodule : ssa_attach_properties

bind ssa_attach ssa_attach_properties u_props (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .addr(addr),
   .as_n(as_n),
   .rw(rw), .low_byte_strobe_n(low_byte_strobe_n), .high_byte_strobe_n(high_byte_strobe_n),
   .valid_memory_addr_n(valid_memory_addr_n), .data_oe_n(data_oe_n),
   .valid_peripheral_addr_n(valid_peripheral_addr_n), .eclk(eclk));

// ==== tb/ssa_bus_master.sv ====
// Purpose: Processor bus master running synchronous peripheral cycles
// Assumes: Starts each cycle just after the enable clock falls
// Notes:   Released bus lines show inverted data, not the last value
module ssa_bus_master (
   input  wire logic                       ref_clk,
   input  wire logic                       eclk,
   input  wire logic                       valid_peripheral_addr_n,
   input  wire logic [15:0]                data_out,
   output logic      [ssa_pkg::ADDR_W-1:0] addr,
   output logic                            as_n,
   output logic                            rw,
   output logic      [1:0]                 strobe_n,
   output logic                            valid_memory_addr_n,
   output logic      [15:0]                data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import ssa_pkg::*;
   initial begin
      addr = '0;
      as_n = 1'b1;
      rw = 1'b1;
      strobe_n = 2'b11;
      valid_memory_addr_n = 1'b1;
      data_in = 16'h0000;
   end
   task automatic cyc(input logic [ADDR_W-1:0] a, input logic r, input logic [1:0] sn, input logic [15:0] wd,
                      input bit use_vma, output logic [15:0] rd, output bit ok);
      int n;
      n = 0;
      ok = 0;
      rd = 16'h0000;
      while (eclk !== 1'b1) @(posedge ref_clk);
      while (eclk !== 1'b0) @(posedge ref_clk);
      as_n <= 1'b0;
      addr <= a;
      rw <= r;
      strobe_n <= sn;
      data_in <= wd;
      @(posedge ref_clk);
      while (valid_peripheral_addr_n !== 1'b0 && n < 4) begin
         @(posedge ref_clk);
         n++;
      end
      if (n < 4) begin
         ok = 1;
         valid_memory_addr_n <= !use_vma;
         while (eclk !== 1'b1) @(posedge ref_clk);
         while (eclk !== 1'b0) @(posedge ref_clk);
         rd = data_out;
      end
      as_n <= 1'b1;
      valid_memory_addr_n <= 1'b1;
      strobe_n <= 2'b11;
      data_in <= ~wd;
      addr <= ~a;
      repeat (2) @(posedge ref_clk);
   endtask : cyc
endmodule : ssa_bus_master

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the serial adapter bus attachment
// Assumes: Serial outputs looped back to the serial inputs
// Notes:   Lane strobes: bit0 low lane, bit1 high lane
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ssa_pkg::*;
   localparam int FRAME_WAIT = FRAME_BITS * BAUD_DIV + 40;
   logic              ref_clk;
   logic              resetn;
   logic              clk_en;
   logic [ADDR_W-1:0] addr;
   logic              as_n;
   logic              rw;
   logic [1:0]        strobe_n;
   logic              valid_memory_addr_n;
   logic [15:0]       data_in;
   logic [15:0]       data_out;
   logic [15:0]       data_oe_n;
   logic              valid_peripheral_addr_n;
   logic              eclk;
   logic [1:0]        tx_serial;
   logic [1:0]        irq_n;
   int                n_mismatch = 0;
   int                check_count = 0;
   ssa_attach dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .addr(addr), .as_n(as_n), .rw(rw),
      .low_byte_strobe_n(strobe_n[0]), .high_byte_strobe_n(strobe_n[1]),
      .valid_memory_addr_n(valid_memory_addr_n), .data_in(data_in), .data_out(data_out),
      .data_oe_n(data_oe_n), .valid_peripheral_addr_n(valid_peripheral_addr_n), .eclk(eclk),
      .rx_serial(tx_serial), .tx_serial(tx_serial), .irq_n(irq_n));
   ssa_bus_master m (.ref_clk(ref_clk), .eclk(eclk), .valid_peripheral_addr_n(valid_peripheral_addr_n),
      .data_out(data_out), .addr(addr), .as_n(as_n), .rw(rw), .strobe_n(strobe_n),
      .valid_memory_addr_n(valid_memory_addr_n), .data_in(data_in));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   function automatic logic [ADDR_W-1:0] at(input logic sel);
      return {IO_PAGE, 9'h000, 1'b1, 4'h0, sel};
   endfunction : at
   task automatic acc(input logic sel, input logic r, input logic [1:0] sn, input logic [15:0] wd,
                      output logic [15:0] rd);
      bit ok;
      m.cyc(at(sel), r, sn, wd, 1'b1, rd, ok);
      chk({15'h0000, ok}, 16'h0001, "peripheral address");
   endtask : acc
   task automatic t_idle;
      int hi;
      int lo;
      logic seen;
      logic [15:0] rd;
      hi = 0;
      lo = 0;
      seen = 0;
      acc(1'b1, 1'b0, 2'b00, 16'h5A5A, rd);
      repeat (FRAME_WAIT) begin
         @(posedge ref_clk);
         if (tx_serial !== 2'b11) seen = 1;
      end
      chk({15'h0000, seen}, 16'h0000, "transmit in master reset");
      while (eclk !== 1'b0) @(posedge ref_clk);
      while (eclk !== 1'b1) @(posedge ref_clk);
      while (eclk === 1'b1) begin
         @(posedge ref_clk);
         hi++;
      end
      while (eclk === 1'b0) begin
         @(posedge ref_clk);
         lo++;
      end
      chk(16'(hi), 16'(ECLK_HIGH), "eclk high");
      chk(16'(hi + lo), 16'(ECLK_DIV), "eclk period");
      chk(data_oe_n, 16'hFFFF, "bus idle");
      chk({14'h0000, irq_n}, 16'h0003, "irq idle");
      $display("test idle done");
   endtask : t_idle
   task automatic t_freeze;
      logic e0;
      logic moved;
      moved = 0;
      while (eclk !== 1'b1) @(posedge ref_clk);
      clk_en <= 1'b0;
      @(posedge ref_clk);
      e0 = eclk;
      repeat (3 * ECLK_DIV) begin
         @(posedge ref_clk);
         if (eclk !== e0) moved = 1;
      end
      clk_en <= 1'b1;
      chk({15'h0000, moved}, 16'h0000, "eclk while disabled");
      chk({15'h0000, e0}, 16'h0001, "eclk held high");
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_loop;
      logic [15:0] rd;
      acc(1'b0, 1'b0, 2'b00, 16'h0C04, rd);
      acc(1'b0, 1'b1, 2'b00, 16'h0000, rd);
      chk(rd & 16'h7373, 16'h0202, "status empty");
      acc(1'b1, 1'b0, 2'b00, 16'h3CA5, rd);
      repeat (FRAME_WAIT) @(posedge ref_clk);
      acc(1'b0, 1'b1, 2'b00, 16'h0000, rd);
      chk(rd & 16'h7373, 16'h0303, "status ready");
      acc(1'b1, 1'b1, 2'b00, 16'h0000, rd);
      chk(rd, 16'h3CA5, "both lanes data");
      acc(1'b1, 1'b0, 2'b01, 16'h9611, rd);
      repeat (FRAME_WAIT) @(posedge ref_clk);
      acc(1'b0, 1'b1, 2'b00, 16'h0000, rd);
      chk(rd & 16'h7373, 16'h0302, "high lane only");
      acc(1'b1, 1'b1, 2'b01, 16'h0000, rd);
      chk(rd & 16'hFF00, 16'h9600, "high lane data");
      $display("test loop done");
   endtask : t_loop
   task automatic t_refuse;
      logic [ADDR_W-1:0] bad [3];
      logic [1:0] sb [3];
      logic [15:0] rd;
      bit ok;
      bad = '{at(1'b1) & ~23'h000020, at(1'b1) ^ {8'h03, 15'h0000}, at(1'b1)};
      sb = '{2'b00, 2'b00, 2'b11};
      for (int i = 0; i < 3; i++) begin
         m.cyc(bad[i], 1'b1, sb[i], 16'h0000, 1'b1, rd, ok);
         chk({15'h0000, ok}, 16'h0000, "foreign decode");
      end
      m.cyc(at(1'b1), 1'b0, 2'b01, 16'h5500, 1'b0, rd, ok);
      repeat (FRAME_WAIT) @(posedge ref_clk);
      acc(1'b0, 1'b1, 2'b01, 16'h0000, rd);
      chk(rd & 16'h7300, 16'h0200, "write without enable");
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_fifo;
      logic [15:0] rd;
      acc(1'b0, 1'b0, 2'b10, 16'h0080, rd);
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         acc(1'b1, 1'b0, 2'b10, 16'h0010 + 16'(i), rd);
         repeat (FRAME_WAIT) @(posedge ref_clk);
      end
      chk({14'h0000, irq_n}, 16'h0002, "irq pending");
      acc(1'b0, 1'b1, 2'b10, 16'h0000, rd);
      chk(rd & 16'h0073, 16'h0023, "overrun");
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         acc(1'b1, 1'b1, 2'b10, 16'h0000, rd);
         chk(rd & 16'h00FF, 16'h0010 + 16'(i), "buffer order");
      end
      acc(1'b0, 1'b1, 2'b10, 16'h0000, rd);
      chk(rd & 16'h0073, 16'h0002, "drained");
      chk({14'h0000, irq_n}, 16'h0003, "irq cleared");
      $display("test fifo done");
   endtask : t_fifo
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_idle;
      t_freeze;
      t_loop;
      t_refuse;
      t_fifo;
      conclude;
   end
   initial begin
      #2000000;
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      conclude;
   end
endmodule : testbench
